// ---- core/pcsc_pkg.sv ----
package pcsc_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned ADDR_W = 10;
    localparam logic [9:0] ADDR_CAL_CTRL = 10'h018;
    localparam logic [9:0] ADDR_SYNC = 10'h019;
    localparam logic [9:0] ADDR_STAT = 10'h01A;
    localparam logic [9:0] ADDR_MON = 10'h01F;
    localparam logic [9:0] ADDR_UPDATE = 10'h232;
    localparam logic [7:0] CAL_CTRL_RST = 8'h06;
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam int unsigned CAL_NOW_BIT = 0;
    localparam int unsigned CAL_DIV_LSB = 1;
    localparam int unsigned SYNC_LSB = 6;
    localparam int unsigned STAT_DIV_BIT = 7;
    localparam int unsigned MON_THR_BIT = 6;
    localparam int unsigned UPDATE_BIT = 0;
    localparam int unsigned R_W = 14;
    localparam int unsigned A_W = 6;
    localparam int unsigned B_W = 13;
    localparam int unsigned MON_W = 17;
    localparam logic [7:0] CAL_TICKS = 8'h40;
    localparam int unsigned MON_FAST_HZ = 1_020_000;
    localparam int unsigned MON_SLOW_HZ = 6_000;
    // longest period still valid, rounded down
    localparam logic [16:0] MON_FAST_CYC = 17'(CLK_HZ / MON_FAST_HZ);
    localparam int unsigned MON_SLOW_CYC = CLK_HZ / MON_SLOW_HZ;
    localparam logic [16:0] VCO_MON_CYC = 17'h000F0;
    typedef enum logic [1:0] {
        PCSC_SYNC_NONE = 2'b00,
        PCSC_SYNC_ASYNC = 2'b01,
        PCSC_SYNC_SYNC = 2'b10,
        PCSC_SYNC_IDLE = 2'b11
    } pcsc_sync_mode_t;
    typedef enum logic [0:0] {
        PCSC_CAL_IDLE = 1'b0,
        PCSC_CAL_RUN = 1'b1
    } pcsc_cal_state_t;
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pcsc_bus_t;
endpackage : pcsc_pkg

// ---- core/pcsc_cal_div.sv ----
`timescale 1ns/100ps
module pcsc_cal_div (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] div_sel,
    output logic cal_clk_q,
    output logic tick_q
);
    logic [3:0] cnt_q, cnt_d;
    logic clk_d, tick_d;
    logic [3:0] mask;

    always_comb begin
        cnt_d = cnt_q + 4'h1;
        // 00 -> /2, 01 -> /4, 10 -> /8, 11 -> /16
        mask = 4'((5'h02 << div_sel) - 5'h01); // [R1]
        clk_d = cnt_d[div_sel]; // [R12]
        tick_d = ((cnt_d | ~mask) == 4'hF);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            cal_clk_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            cal_clk_q <= clk_d;
            tick_q <= tick_d;
        end
    end

    chk_div_eight: assert property (@(posedge core_clk) disable iff (!rst_n || div_sel != 2'b10)
        tick_q && $stable(div_sel) |=> !tick_q [*7] ##1 tick_q) // [R1]
        else $error("cal tick period not eight at divide-by-8");
    chk_div_sixteen: assert property (@(posedge core_clk) disable iff (!rst_n || div_sel != 2'b11)
        tick_q && $stable(div_sel) |=> !tick_q [*8]) // [R3]
        else $error("cal tick too early at divide-by-16");
endmodule : pcsc_cal_div

// ---- core/pcsc_core.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
// Operation
// R1 - calibration clock divider codes 00..11 give 2, 4, 8, 16; default 16
// R2 - software picks /2 or /4 below 12.5 MHz, /8 below 50 MHz
// R3 - divide-by-16 works at any rate, longest calibration time
// R4 - phase detector rate is reference divided by R counter value
// R5 - calibration starts only on active calibrate-now bit 0 to 1; default 0
// R6 - software writes bit 0, updates, then writes 1, updates again
// R7 - software keeps VCO output divider stable during calibration
// R8 - sync field: 00/11 nothing, 01 async reset, 10 sync reset of R, A, B
// R9 - status divider bit set divides status pin signal by four
// R10 - reference monitor valid above 1.02 MHz, or 6 kHz when bit set
// R11 - reference threshold bit leaves VCO monitor threshold alone
// R12 - calibration clock is reference clock divided by chosen divider
module pcsc_core #(
    parameter int unsigned REF_SLOW_CYC = pcsc_pkg::MON_SLOW_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pcsc_pkg::pcsc_bus_t bus_req,
    output logic [7:0] rd_data_q,
    input wire logic [13:0] r_divide,
    input wire logic sync_n_pin,
    input wire logic fb_pin,
    input wire logic first_reference_input,
    input wire logic second_reference_input,
    input wire logic vco_pin,
    input wire logic status_src,
    output logic cal_clk_q,
    output logic cal_start_q,
    output logic cal_busy_q,
    output logic phase_detector_tick_q,
    output logic [13:0] r_cnt_q,
    output logic [5:0] a_cnt_q,
    output logic [12:0] b_cnt_q,
    output logic status_pin_q,
    output logic first_reference_input_valid_q,
    output logic second_reference_input_valid_q,
    output logic vco_valid_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // shadow copies take writes; active copies move only on update
    logic [7:0] cal_sh_q, cal_sh_d, sync_sh_q, sync_sh_d, stat_sh_q, stat_sh_d;
    logic [7:0] cal_ac_q, cal_ac_d, sync_ac_q, sync_ac_d, stat_ac_q, stat_ac_d;
    logic [7:0] rd_data_d;
    logic upd;
    logic [2:0] mon_valid;

    always_comb begin
        cal_sh_d = cal_sh_q;
        sync_sh_d = sync_sh_q;
        stat_sh_d = stat_sh_q;
        upd = 1'b0;
        if (bus_req.wr) begin
            if (bus_req.addr == pcsc_pkg::ADDR_CAL_CTRL) begin
                cal_sh_d = bus_req.wdata;
            end else if (bus_req.addr == pcsc_pkg::ADDR_SYNC) begin
                sync_sh_d = bus_req.wdata;
            end else if (bus_req.addr == pcsc_pkg::ADDR_STAT) begin
                stat_sh_d = bus_req.wdata;
            end else if (bus_req.addr == pcsc_pkg::ADDR_UPDATE) begin
                upd = bus_req.wdata[pcsc_pkg::UPDATE_BIT];
            end
        end
        cal_ac_d = upd ? cal_sh_q : cal_ac_q;
        sync_ac_d = upd ? sync_sh_q : sync_ac_q;
        stat_ac_d = upd ? stat_sh_q : stat_ac_q;
        rd_data_d = 8'h00;
        if (bus_req.rd) begin
            if (bus_req.addr == pcsc_pkg::ADDR_CAL_CTRL) begin
                rd_data_d = cal_sh_q;
            end else if (bus_req.addr == pcsc_pkg::ADDR_SYNC) begin
                rd_data_d = sync_sh_q;
            end else if (bus_req.addr == pcsc_pkg::ADDR_STAT) begin
                rd_data_d = stat_sh_q;
            end else if (bus_req.addr == pcsc_pkg::ADDR_MON) begin
                rd_data_d = {4'h0, mon_valid, cal_busy_q};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_sh_q <= pcsc_pkg::CAL_CTRL_RST;
            sync_sh_q <= pcsc_pkg::SYNC_RST;
            stat_sh_q <= pcsc_pkg::STAT_RST;
            cal_ac_q <= pcsc_pkg::CAL_CTRL_RST;
            sync_ac_q <= pcsc_pkg::SYNC_RST;
            stat_ac_q <= pcsc_pkg::STAT_RST;
            rd_data_q <= 8'h00;
        end else begin
            cal_sh_q <= cal_sh_d;
            sync_sh_q <= sync_sh_d;
            stat_sh_q <= stat_sh_d;
            cal_ac_q <= cal_ac_d;
            sync_ac_q <= sync_ac_d;
            stat_ac_q <= stat_ac_d;
            rd_data_q <= rd_data_d;
        end
    end

    chk_update_copy: assert property (upd |=> cal_ac_q == $past(cal_sh_q)) // [R5]
        else $error("active copy did not take shadow on update");
    // calibration clock and sequencer
    logic cal_tick;
    pcsc_cal_div u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .div_sel(cal_ac_q[pcsc_pkg::CAL_DIV_LSB +: 2]), // [R1] [R12]
        .cal_clk_q(cal_clk_q),
        .tick_q(cal_tick)
    );
    pcsc_pkg::pcsc_cal_state_t cal_st_q, cal_st_d;
    logic [7:0] cal_cnt_q, cal_cnt_d;
    logic now_prev_q, start_d, busy_d;
    always_comb begin
        cal_st_d = cal_st_q;
        cal_cnt_d = cal_cnt_q;
        // edge of the active copy only, so shadow writes alone never start it
        start_d = cal_ac_q[pcsc_pkg::CAL_NOW_BIT] && !now_prev_q; // [R5]
        case (cal_st_q)
            pcsc_pkg::PCSC_CAL_IDLE: begin
                if (start_d) begin
                    cal_st_d = pcsc_pkg::PCSC_CAL_RUN;
                    cal_cnt_d = 8'h00;
                end
            end
            pcsc_pkg::PCSC_CAL_RUN: begin
                // length counted in calibration clocks, so /16 runs longest
                if (cal_tick) begin // [R3]
                    cal_cnt_d = cal_cnt_q + 8'h01;
                    if (cal_cnt_d == pcsc_pkg::CAL_TICKS) begin
                        cal_st_d = pcsc_pkg::PCSC_CAL_IDLE;
                    end
                end
            end
            default: cal_st_d = pcsc_pkg::PCSC_CAL_IDLE;
        endcase
        busy_d = (cal_st_d == pcsc_pkg::PCSC_CAL_RUN);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_st_q <= pcsc_pkg::PCSC_CAL_IDLE;
            cal_cnt_q <= 8'h00;
            now_prev_q <= 1'b0;
            cal_start_q <= 1'b0;
            cal_busy_q <= 1'b0;
        end else begin
            cal_st_q <= cal_st_d;
            cal_cnt_q <= cal_cnt_d;
            now_prev_q <= cal_ac_q[pcsc_pkg::CAL_NOW_BIT];
            cal_start_q <= start_d && (cal_st_q == pcsc_pkg::PCSC_CAL_IDLE);
            cal_busy_q <= busy_d;
        end
    end

    chk_cal_start_edge: assert property (cal_start_q |-> $past(cal_ac_q[pcsc_pkg::CAL_NOW_BIT])
        && !$past(cal_ac_q[pcsc_pkg::CAL_NOW_BIT], 2)) // [R5]
        else $error("calibration started without active bit rising");
    chk_cal_busy_run: assert property (cal_start_q |-> cal_busy_q ##1 cal_busy_q) // [R12]
        else $error("calibration start not followed by busy");

    // sync pin, feedback pin: two flops before use
    logic [1:0] sync_sh_pin_q;
    logic [2:0] fb_sh_q;
    logic sync_pend_q, sync_pend_d, sync_act, clr_async, clr_sync;
    logic [13:0] r_cnt_d;
    logic [5:0] a_cnt_d;
    logic [12:0] b_cnt_d;
    logic pd_tick_d, fb_edge;
    pcsc_pkg::pcsc_sync_mode_t smode;

    always_comb begin
        smode = pcsc_pkg::pcsc_sync_mode_t'(sync_ac_q[pcsc_pkg::SYNC_LSB +: 2]);
        sync_act = !sync_sh_pin_q[1];
        fb_edge = fb_sh_q[1] && !fb_sh_q[2];
        // async mode holds counters clear for as long as sync is low
        clr_async = sync_act && (smode == pcsc_pkg::PCSC_SYNC_ASYNC); // [R8]
        // sync mode waits for the phase detector boundary; set wins
        sync_pend_d = (sync_act && smode == pcsc_pkg::PCSC_SYNC_SYNC) // [R8]
                      || (sync_pend_q && !phase_detector_tick_q);
        clr_sync = sync_pend_q && phase_detector_tick_q; // [R8]
        pd_tick_d = (r_divide <= 14'h0001) || (r_cnt_q >= r_divide - 14'h0001); // [R4]
        r_cnt_d = pd_tick_d ? 14'h0000 : r_cnt_q + 14'h0001;
        a_cnt_d = fb_edge ? a_cnt_q + 6'h01 : a_cnt_q;
        b_cnt_d = (fb_edge && a_cnt_q == 6'h3F) ? b_cnt_q + 13'h0001 : b_cnt_q;
        if (clr_async || clr_sync) begin
            r_cnt_d = 14'h0000;
            a_cnt_d = 6'h00;
            b_cnt_d = 13'h0000;
            pd_tick_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_sh_pin_q <= 2'h3;
            fb_sh_q <= 3'h0;
            sync_pend_q <= 1'b0;
            r_cnt_q <= 14'h0000;
            a_cnt_q <= 6'h00;
            b_cnt_q <= 13'h0000;
            phase_detector_tick_q <= 1'b0;
        end else begin
            sync_sh_pin_q <= {sync_sh_pin_q[0], sync_n_pin};
            fb_sh_q <= {fb_sh_q[1:0], fb_pin};
            sync_pend_q <= sync_pend_d;
            r_cnt_q <= r_cnt_d;
            a_cnt_q <= a_cnt_d;
            b_cnt_q <= b_cnt_d;
            phase_detector_tick_q <= pd_tick_d;
        end
    end

    chk_sync_async: assert property (clr_async |=> r_cnt_q == 14'h0000 && a_cnt_q == 6'h00
        && b_cnt_q == 13'h0000) // [R8]
        else $error("async sync mode did not clear counters");
    chk_sync_aligned: assert property (clr_sync |=> r_cnt_q == 14'h0000 && b_cnt_q == 13'h0000) // [R8]
        else $error("sync mode did not clear at phase detector boundary");
    chk_pd_rate: assert property (phase_detector_tick_q && r_divide >= 14'h0002
        |=> !phase_detector_tick_q) // [R4]
        else $error("phase detector tick faster than reference over R");

    // status pin, optional divide by four
    logic st_prev_q, st_pin_d;
    logic [1:0] st_cnt_q, st_cnt_d;

    always_comb begin
        st_cnt_d = (status_src && !st_prev_q) ? st_cnt_q + 2'h1 : st_cnt_q;
        st_pin_d = stat_ac_q[pcsc_pkg::STAT_DIV_BIT] ? st_cnt_d[1] : status_src; // [R9]
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_prev_q <= 1'b0;
            st_cnt_q <= 2'h0;
            status_pin_q <= 1'b0;
        end else begin
            st_prev_q <= status_src;
            st_cnt_q <= st_cnt_d;
            status_pin_q <= st_pin_d;
        end
    end

    chk_status_pass: assert property (!stat_ac_q[pcsc_pkg::STAT_DIV_BIT]
        |=> status_pin_q == $past(status_src)) // [R9]
        else $error("status pin altered with divider off");

    // frequency monitors: 0, 1 references, 2 VCO
    logic [2:0] mon_pin;
    logic [16:0] mon_cnt [3];
    assign mon_pin = {vco_pin, second_reference_input, first_reference_input};
    for (genvar i = 0; i < 3; i++) begin : g_mon
        logic [2:0] sh_q, sh_d;
        logic [16:0] cnt_q, cnt_d, lim;
        logic val_q, val_d;
        always_comb begin
            sh_d = {sh_q[1:0], mon_pin[i]};
            lim = (i == 2) ? pcsc_pkg::VCO_MON_CYC // [R11]
                : stat_ac_q[pcsc_pkg::MON_THR_BIT] ? 17'(REF_SLOW_CYC)
                : pcsc_pkg::MON_FAST_CYC; // [R10]
            cnt_d = cnt_q;
            if (sh_q[1] && !sh_q[2]) begin
                cnt_d = 17'h00000;
            end else if (cnt_q < lim) begin
                cnt_d = cnt_q + 17'h00001;
            end
            val_d = (cnt_d < lim);
        end
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                sh_q <= 3'h0;
                cnt_q <= 17'h00000;
                val_q <= 1'b0;
            end else begin
                sh_q <= sh_d;
                cnt_q <= cnt_d;
                val_q <= val_d;
            end
        end
        assign mon_valid[i] = val_q;
        assign mon_cnt[i] = cnt_q;
    end

    assign first_reference_input_valid_q = mon_valid[0];
    assign second_reference_input_valid_q = mon_valid[1];
    assign vco_valid_q = mon_valid[2];
    // no synced edge this cycle, so a saturated count must read invalid
    chk_ref_fast: assert property (!stat_ac_q[pcsc_pkg::MON_THR_BIT]
        && mon_cnt[0] >= pcsc_pkg::MON_FAST_CYC
        && !(g_mon[0].sh_q[1] && !g_mon[0].sh_q[2]) |=> !first_reference_input_valid_q) // [R10]
        else $error("reference valid below fast threshold");
    chk_vco_fixed: assert property (mon_cnt[2] >= pcsc_pkg::VCO_MON_CYC
        && !(g_mon[2].sh_q[1] && !g_mon[2].sh_q[2]) |=> !vco_valid_q) // [R11]
        else $error("VCO monitor threshold moved");
endmodule : pcsc_core

// ---- sim/pcsc_core_tb.sv ----
`timescale 1ns/100ps
module pcsc_core_tb;
    logic core_clk;
    logic rst_n;
    pcsc_pkg::pcsc_bus_t bus_req;
    logic [7:0] rd_data_q;
    logic [13:0] r_divide;
    logic sync_n_pin, fb_pin, first_reference_input, second_reference_input, vco_pin, status_src;
    logic cal_clk_q, cal_start_q, cal_busy_q, phase_detector_tick_q, status_pin_q;
    logic [13:0] r_cnt_q;
    logic [5:0] a_cnt_q;
    logic [12:0] b_cnt_q;
    logic first_reference_input_valid_q, second_reference_input_valid_q, vco_valid_q;
    logic [15:0] lfsr_q;
    logic [18:0] held;
    logic [7:0] d;
    logic p;
    int fail_count, num_checks, n, c, r, k;

    pcsc_core #(.REF_SLOW_CYC(500)) u_pcsc_core (
        .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data_q(rd_data_q),
        .r_divide(r_divide), .sync_n_pin(sync_n_pin), .fb_pin(fb_pin),
        .first_reference_input(first_reference_input),
        .second_reference_input(second_reference_input), .vco_pin(vco_pin),
        .status_src(status_src), .cal_clk_q(cal_clk_q), .cal_start_q(cal_start_q),
        .cal_busy_q(cal_busy_q), .phase_detector_tick_q(phase_detector_tick_q),
        .r_cnt_q(r_cnt_q), .a_cnt_q(a_cnt_q), .b_cnt_q(b_cnt_q), .status_pin_q(status_pin_q),
        .first_reference_input_valid_q(first_reference_input_valid_q), .second_reference_input_valid_q(second_reference_input_valid_q), .vco_valid_q(vco_valid_q)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic cyc(input int cnt);
        repeat (cnt) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [9:0] a, input logic [7:0] wd);
        @(posedge core_clk);
        bus_req <= '{a, wd, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask : wr

    task automatic upd();
        wr(pcsc_pkg::ADDR_UPDATE, 8'h01);
    endtask : upd

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string msg);
        @(posedge core_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        check(rd_data_q, exp, msg);
        cyc(1);
        check(rd_data_q, 8'h00, "read data not cleared");
    endtask : rd_chk

    // counters must be cleared only by modes 01 and 10
    task automatic sync_case(input logic [1:0] mode, input logic clr);
        wr(pcsc_pkg::ADDR_SYNC, {mode, 6'h00});
        upd();
        // enough edges to wrap A and step B
        repeat (140) begin
            fb_pin <= ~fb_pin;
            cyc(2);
        end
        cyc(4);
        held = {b_cnt_q, a_cnt_q};
        sync_n_pin <= 1'b0;
        cyc(int'(r_divide) + 8);
        check({b_cnt_q, a_cnt_q}, clr ? 19'h00000 : held, "sync counters");
        if (mode == 2'b01)
            check(r_cnt_q, 14'h0000, "async hold r");
        sync_n_pin <= 1'b1;
        cyc(6);
        $display("sync mode %0d done", mode);
    endtask : sync_case

    task automatic stat_case(input logic divb, input int exp);
        wr(pcsc_pkg::ADDR_STAT, {divb, 7'h00});
        upd();
        cyc(6);
        n = 0;
        p = status_pin_q;
        repeat (16) begin
            status_src <= ~status_src;
            repeat (2) begin
                cyc(1);
                if (status_pin_q !== p)
                    n++;
                p = status_pin_q;
            end
        end
        check(n, exp, "status pin transitions");
        $display("status divider %0d done", divb);
    endtask : stat_case

    task automatic mon_case(input logic thr, input int gap, input logic er, input logic ev);
        wr(pcsc_pkg::ADDR_STAT, {1'b0, thr, 6'h00});
        upd();
        repeat (3) begin
            first_reference_input <= 1'b1;
            second_reference_input <= 1'b1;
            vco_pin <= 1'b1;
            cyc(4);
            first_reference_input <= 1'b0;
            second_reference_input <= 1'b0;
            vco_pin <= 1'b0;
            cyc(gap - 4);
        end
        check({first_reference_input_valid_q, second_reference_input_valid_q}, {er, er}, "ref valid");
        check(vco_valid_q, ev, "vco valid");
        rd_chk(pcsc_pkg::ADDR_MON, {4'h0, ev, er, er, 1'b0}, "status reg");
        $display("monitor thr %0d gap %0d done", thr, gap);
    endtask : mon_case

    initial begin
        repeat (100000) @(posedge core_clk);
        fail_count++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        r_divide = 14'h000A;
        sync_n_pin = 1'b1;
        {fb_pin, first_reference_input, second_reference_input, vco_pin, status_src} = 5'h00;
        lfsr_q = 16'h0031;
        fail_count = 0;
        num_checks = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(pcsc_pkg::ADDR_CAL_CTRL, 8'h06, "cal ctrl reset");
        rd_chk(pcsc_pkg::ADDR_SYNC, 8'h00, "sync reset");
        rd_chk(pcsc_pkg::ADDR_STAT, 8'h00, "stat reset");
        rd_chk(pcsc_pkg::ADDR_UPDATE, 8'h00, "update reads zero");
        rd_chk(10'h3FF, 8'h00, "unmapped read");
        $display("reset values done");
        repeat (6) begin
            d = rnd();
            wr(pcsc_pkg::ADDR_SYNC, d);
            rd_chk(pcsc_pkg::ADDR_SYNC, d, "sync rw");
            d = rnd();
            wr(pcsc_pkg::ADDR_STAT, d);
            rd_chk(pcsc_pkg::ADDR_STAT, d, "stat rw");
            d = rnd();
            wr(pcsc_pkg::ADDR_CAL_CTRL, d);
            rd_chk(pcsc_pkg::ADDR_CAL_CTRL, d, "cal rw");
            wr(10'h3FF, d);
        end
        wr(pcsc_pkg::ADDR_SYNC, 8'h00);
        wr(pcsc_pkg::ADDR_STAT, 8'h00);
        wr(pcsc_pkg::ADDR_CAL_CTRL, 8'h06);
        $display("random register access done");
        for (k = 0; k < 5; k++) begin
            // divide by one holds the tick high every cycle
            r_divide <= (k == 0) ? 14'h0002 : (k == 1) ? 14'h0001 : 14'(2 + rnd() % 32);
            cyc(80);
            c = 0;
            while (phase_detector_tick_q !== 1'b1 && c < 80) begin
                cyc(1);
                c++;
            end
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (phase_detector_tick_q !== 1'b1 && n < 80);
            check(n, int'(r_divide), "tick spacing");
        end
        $display("phase detector rate done");
        r_divide <= 14'h0028; // 6.25 MHz keeps even /2 legal
        for (k = 0; k < 4; k++) begin
            // low-rate tick keeps every divider legal for the caller
            wr(pcsc_pkg::ADDR_CAL_CTRL, 8'(k << 1));
            upd(); // 0 then 1, each followed by an update
            wr(pcsc_pkg::ADDR_CAL_CTRL, 8'(k << 1) | 8'h01);
            upd(); // no output divider exists here to disturb mid-run
            n = 0;
            while (cal_start_q !== 1'b1 && n < 20) begin
                cyc(1);
                n++;
            end
            check(n < 20, 1, "cal start pulse");
            c = 0;
            r = 0;
            p = cal_clk_q;
            while (cal_busy_q === 1'b1 && c < 1200) begin
                cyc(1);
                c++;
                if (cal_clk_q === 1'b1 && p !== 1'b1)
                    r++;
                p = cal_clk_q;
            end
            check(r >= 63 && r <= 65, 1, "cal clock rises");
            check(c >= 63 * (2 << k) && c <= 64 * (2 << k) + 4, 1, "cal length");
            upd();
            n = 0;
            repeat (30) begin
                cyc(1);
                if (cal_start_q === 1'b1)
                    n++;
            end
            check(n, 0, "restart without 0 to 1");
            $display("calibration divider code %0d done", k);
        end
        sync_case(2'b00, 1'b0);
        sync_case(2'b01, 1'b1);
        sync_case(2'b10, 1'b1);
        sync_case(2'b11, 1'b0);
        stat_case(1'b0, 16);
        stat_case(1'b1, 4);
        mon_case(1'b0, 100, 1'b1, 1'b1);
        mon_case(1'b1, 100, 1'b1, 1'b1);
        mon_case(1'b0, 300, 1'b0, 1'b0);
        mon_case(1'b1, 300, 1'b1, 1'b0);
        conclude();
    end
endmodule : pcsc_core_tb
